// ---- hdl/core_cfg.svh ----
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH

// Program space vectors and default implemented limit
`define RESET_VECTOR  13'h0000
`define IRQ_VECTOR    13'h0004
`define PROG_LAST_DEF 13'h07ff

// Core register offsets inside a bank
`define ADDR_INDIRECT_ACCESS_PORT     7'h00
`define ADDR_PCL      7'h02
`define ADDR_STATUS   7'h03
`define ADDR_FSR      7'h04
`define ADDR_FETCH_POINTER_UPPER_HOLD   7'h0a
`define RAM_BASE      7'h0c

// Status register bit positions, reset value, writable bits
`define BIT_RP0       5
`define BIT_Z         2
`define BIT_DC        1
`define BIT_C         0
`define STATUS_RST    8'h18
`define STATUS_WMASK  8'h27

// Reset values of the remaining core state
`define FETCH_POINTER_UPPER_HOLD_RST    5'h00
`define FSR_RST       8'h00
`define W_RST         8'h00

// Instruction word used to fill a flushed slot
`define NOP_WORD      14'h0000

// Data RAM depth covering both banks
`define RAM_DEPTH_DEF 256

`endif

// ---- hdl/core_pkg.sv ----
package core_pkg;

	typedef enum logic [1:0] {
		PH_ONE   = 2'b00,
		PH_TWO   = 2'b01,
		PH_THREE = 2'b10,
		PH_FOUR  = 2'b11
	} phase_t;

	typedef enum logic [4:0] {
		AL_NONE   = 5'b00000,
		AL_LOAD   = 5'b00001,
		AL_PASS_A = 5'b00010,
		AL_PASS_W = 5'b00011,
		AL_ZERO   = 5'b00100,
		AL_ADD    = 5'b00101,
		AL_SUB    = 5'b00110,
		AL_AND    = 5'b00111,
		AL_IOR    = 5'b01000,
		AL_XOR    = 5'b01001,
		AL_INC    = 5'b01010,
		AL_DEC    = 5'b01011,
		AL_COM    = 5'b01100,
		AL_RRF    = 5'b01101,
		AL_RLF    = 5'b01110,
		AL_SWAP   = 5'b01111,
		AL_BCF    = 5'b10000,
		AL_BSF    = 5'b10001
	} alu_op_t;

	typedef struct packed {
		logic [7:0] res;
		logic       c;
		logic       dc;
		logic       c_upd;
		logic       dc_upd;
		logic       z_upd;
	} alu_out_t;

endpackage

// ---- hdl/data_ram_if.sv ----
`timescale 1ns/10ps

interface data_ram_if;
	logic       rd_en;
	logic       wr_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport core (output rd_en, output wr_en, output addr, output wdata, input rdata);
	modport ram  (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface

// ---- hdl/data_ram.sv ----
`timescale 1ns/10ps
`include "core_cfg.svh"

module data_ram #(
	parameter int DEPTH = `RAM_DEPTH_DEF
) (
	input  wire logic mclk_i,
	input  wire logic rst_i,
	data_ram_if.ram   bus
);

	// The full 8-bit bank-plus-offset address must land inside the array
	if (DEPTH < 256) begin : g_check
		$error("data_ram DEPTH must cover 256 locations");
	end

	logic [7:0] mem [DEPTH];
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;

	// Read data is held until the next read strobe
	always_comb begin
		rdata_next = rdata_reg;
		if (bus.rd_en) begin
			rdata_next = mem[bus.addr];
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// Array storage, no reset
	always_ff @(posedge mclk_i) begin
		if (bus.wr_en) begin
			mem[bus.addr] <= bus.wdata;
		end
	end

	assign bus.rdata = rdata_reg;

endmodule

// ---- hdl/core_sequencer.sv ----
`timescale 1ns/10ps
`include "core_cfg.svh"

// What this block does
// [RQ1] Input clock divided by four into four non-overlapping phases per cycle.
// [RQ2] Fetch pointer advances in phase one; fetched word latched in phase four.
// [RQ3] Fetch of next instruction overlaps execution of current one.
// [RQ4] Pointer-changing instructions discard the fetched word, costing two cycles.
// [RQ5] Latched instruction decoded and executed across phases two to four.
// [RQ6] Operand read in phase two, destination written in phase four.
// [RQ7] Instruction words are 14 bits on a bus apart from 8-bit data.
// [RQ8] Fetch pointer is 13 bits wide, an 8K word space.
// [RQ9] Addresses beyond implemented memory wrap onto implemented locations.
// [RQ10] Fetch starts at 0000h after reset; interrupts vector to 0004h.
// [RQ11] Status bit five selects bank 1 when set, bank 0 when clear.
// [RQ12] Each bank spans to 7Fh: core registers low, RAM above.
// [RQ13] Core registers appear at the same offset in both banks.
// [RQ14] Register file reached directly or through the indirect pointer.
// [RQ15] 8-bit unit adds, subtracts, shifts and does logic, two's complement.
// [RQ16] Two-operand ops use working register and file or literal.
// [RQ17] Working register is not mapped at any data address.
// [RQ18] Carry, nibble carry and zero flags updated per instruction.
// [RQ19] Subtraction: carry means no borrow, nibble carry means no nibble borrow.
// [RQ20] In RC mode the cycle rate output runs at a quarter input clock.
// [RQ21] Master clear held low keeps the device in reset.
// [RQ22] Direct address combines bank select bit with 7-bit instruction field.
module core_sequencer #(
	parameter logic [12:0] PROG_LAST = `PROG_LAST_DEF,
	parameter int          RAM_DEPTH = `RAM_DEPTH_DEF
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        master_clear_pin_n_i,
	input  wire logic        rc_mode_i,
	input  wire logic        irq_req_i,
	input  wire logic [13:0] prog_data_i,
	output logic      [12:0] prog_addr_o,
	output logic      [1:0]  phase_o,
	output logic             cycle_rate_o,
	output logic             irq_ack_o,
	output logic      [7:0]  w_o,
	output logic      [7:0]  status_o
);

	// Implemented limit must be one less than a power of two for wrapping
	if (((PROG_LAST + 13'h0001) & PROG_LAST) != 13'h0000) begin : g_check
		$error("PROG_LAST must be a power of two minus one");
	end

	data_ram_if ram_if ();

	data_ram #(
		.DEPTH (RAM_DEPTH)
	) u_ram (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.bus    (ram_if)
	);

	core_pkg::phase_t   phase_reg;
	core_pkg::phase_t   phase_next;
	logic [12:0]        pc_reg;
	logic [12:0]        pc_next;
	logic [12:0]        fetch_addr_reg;
	logic [12:0]        fetch_addr_next;
	logic [13:0]        opcode_reg;
	logic [13:0]        opcode_next;
	logic [7:0]         w_reg;
	logic [7:0]         w_next;
	logic [7:0]         status_reg;
	logic [7:0]         status_next;
	logic [7:0]         fsr_reg;
	logic [7:0]         fsr_next;
	logic [7:0]         operand_reg;
	logic [7:0]         operand_next;
	logic [4:0]         fetch_pointer_upper_hold_reg;
	logic [4:0]         fetch_pointer_upper_hold_next;
	logic               cycle_rate_reg;
	logic               cycle_rate_next;
	logic               irq_ack_reg;
	logic               irq_ack_next;

	logic [6:0]         f_field;
	logic [7:0]         dmem_addr;
	logic               is_ram;
	logic [7:0]         sfr_rd;
	core_pkg::alu_op_t  alu_op;
	logic               use_lit;
	logic               wr_file;
	logic               wr_w;
	logic               is_jump;
	logic               skip_zero;
	logic               bit_test;
	logic               bit_want;
	logic [7:0]         alu_a;
	core_pkg::alu_out_t alu_res;
	logic               take_skip;
	logic               pcl_write;
	logic               flush;
	logic [12:0]        jump_target;

	// Arithmetic unit: a is file operand or literal, w the working register
	function automatic core_pkg::alu_out_t alu_calc(
		input core_pkg::alu_op_t op,
		input logic [7:0]        a,
		input logic [7:0]        w,
		input logic [2:0]        bsel,
		input logic              cin
	);
		core_pkg::alu_out_t o;
		logic [8:0]         s;
		logic [4:0]         h;
		o = '0;
		s = 9'h000;
		h = 5'h00;
		o.z_upd = 1'b1;
		case (op)
			core_pkg::AL_LOAD: begin
				o.res = a;
				o.z_upd = 1'b0;
			end
			core_pkg::AL_PASS_A: o.res = a;
			core_pkg::AL_PASS_W: begin
				o.res = w;
				o.z_upd = 1'b0;
			end
			core_pkg::AL_ZERO: o.res = 8'h00;
			core_pkg::AL_ADD: begin
				s = {1'b0, a} + {1'b0, w};
				h = {1'b0, a[3:0]} + {1'b0, w[3:0]};
				o.res = s[7:0];
				o.c = s[8];
				o.dc = h[4];
				o.c_upd = 1'b1;
				o.dc_upd = 1'b1;
			end
			core_pkg::AL_SUB: begin
				s = {1'b0, a} + {1'b0, ~w} + 9'h001; // [RQ15] [RQ19]
				h = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
				o.res = s[7:0];
				o.c = s[8];
				o.dc = h[4];
				o.c_upd = 1'b1;
				o.dc_upd = 1'b1;
			end
			core_pkg::AL_AND: o.res = a & w;
			core_pkg::AL_IOR: o.res = a | w;
			core_pkg::AL_XOR: o.res = a ^ w;
			core_pkg::AL_INC: o.res = a + 8'h01;
			core_pkg::AL_DEC: o.res = a - 8'h01;
			core_pkg::AL_COM: o.res = ~a;
			core_pkg::AL_RRF: begin
				o.res = {cin, a[7:1]};
				o.c = a[0];
				o.c_upd = 1'b1;
				o.z_upd = 1'b0;
			end
			core_pkg::AL_RLF: begin
				o.res = {a[6:0], cin};
				o.c = a[7];
				o.c_upd = 1'b1;
				o.z_upd = 1'b0;
			end
			core_pkg::AL_SWAP: begin
				o.res = {a[3:0], a[7:4]};
				o.z_upd = 1'b0;
			end
			core_pkg::AL_BCF: begin
				o.res = a & ~(8'h01 << bsel);
				o.z_upd = 1'b0;
			end
			core_pkg::AL_BSF: begin
				o.res = a | (8'h01 << bsel);
				o.z_upd = 1'b0;
			end
			default: begin
				o.res = a;
				o.z_upd = 1'b0;
			end
		endcase
		return o;
	endfunction

	// Data address: indirect through the pointer, else bank bit plus field
	assign f_field   = opcode_reg[6:0];
	assign dmem_addr = (f_field == `ADDR_INDIRECT_ACCESS_PORT) ? fsr_reg : // [RQ14]
		{status_reg[`BIT_RP0], f_field}; // [RQ11] [RQ22]
	assign is_ram    = (dmem_addr[6:0] >= `RAM_BASE); // [RQ12]

	// Core registers decode on the in-bank offset only, so both banks see them
	always_comb begin
		case (dmem_addr[6:0]) // [RQ13]
			`ADDR_PCL:    sfr_rd = pc_reg[7:0];
			`ADDR_STATUS: sfr_rd = status_reg;
			`ADDR_FSR:    sfr_rd = fsr_reg;
			`ADDR_FETCH_POINTER_UPPER_HOLD: sfr_rd = {3'h0, fetch_pointer_upper_hold_reg};
			default:      sfr_rd = 8'h00; // Indirect-through-itself and gaps read zero
		endcase
	end

	// Instruction decode of the latched word
	always_comb begin
		alu_op = core_pkg::AL_NONE;
		use_lit = 1'b0;
		wr_file = 1'b0;
		wr_w = 1'b0;
		is_jump = 1'b0;
		skip_zero = 1'b0;
		bit_test = 1'b0;
		bit_want = 1'b0;
		case (opcode_reg[13:12]) // [RQ5]
			2'b00: begin
				case (opcode_reg[11:8])
					4'h0: alu_op = core_pkg::AL_PASS_W;
					4'h1: alu_op = core_pkg::AL_ZERO;
					4'h2: alu_op = core_pkg::AL_SUB;
					4'h3: alu_op = core_pkg::AL_DEC;
					4'h4: alu_op = core_pkg::AL_IOR;
					4'h5: alu_op = core_pkg::AL_AND;
					4'h6: alu_op = core_pkg::AL_XOR;
					4'h7: alu_op = core_pkg::AL_ADD;
					4'h8: alu_op = core_pkg::AL_PASS_A;
					4'h9: alu_op = core_pkg::AL_COM;
					4'ha: alu_op = core_pkg::AL_INC;
					4'hb: alu_op = core_pkg::AL_DEC;
					4'hc: alu_op = core_pkg::AL_RRF;
					4'hd: alu_op = core_pkg::AL_RLF;
					4'he: alu_op = core_pkg::AL_SWAP;
					default: alu_op = core_pkg::AL_INC;
				endcase
				skip_zero = (opcode_reg[11:8] == 4'hb) || (opcode_reg[11:8] == 4'hf);
				wr_file = opcode_reg[7];
				wr_w = !opcode_reg[7] && (opcode_reg[11:8] != 4'h0); // [RQ16]
			end
			2'b01: begin
				case (opcode_reg[11:10])
					2'b00: alu_op = core_pkg::AL_BCF;
					2'b01: alu_op = core_pkg::AL_BSF;
					default: alu_op = core_pkg::AL_NONE;
				endcase
				wr_file = !opcode_reg[11];
				bit_test = opcode_reg[11];
				bit_want = opcode_reg[10];
			end
			2'b10: is_jump = 1'b1;
			default: begin
				use_lit = 1'b1;
				wr_w = 1'b1;
				case (opcode_reg[11:8])
					4'h0, 4'h1, 4'h2, 4'h3: alu_op = core_pkg::AL_LOAD;
					4'h8: alu_op = core_pkg::AL_IOR;
					4'h9: alu_op = core_pkg::AL_AND;
					4'ha: alu_op = core_pkg::AL_XOR;
					4'hc, 4'hd: alu_op = core_pkg::AL_SUB;
					4'he, 4'hf: alu_op = core_pkg::AL_ADD;
					default: wr_w = 1'b0;
				endcase
			end
		endcase
	end

	// Arithmetic and branch conditions seen during phase four
	assign alu_a       = use_lit ? opcode_reg[7:0] : operand_reg; // [RQ16]
	assign alu_res     = alu_calc(alu_op, alu_a, w_reg, opcode_reg[9:7], status_reg[`BIT_C]);
	assign take_skip   = (skip_zero && (alu_res.res == 8'h00)) ||
		(bit_test && (operand_reg[opcode_reg[9:7]] == bit_want));
	assign pcl_write   = wr_file && !is_ram && (dmem_addr[6:0] == `ADDR_PCL);
	assign flush       = is_jump || take_skip || pcl_write;
	assign jump_target = {fetch_pointer_upper_hold_reg[4:3], opcode_reg[10:0]};

	// RAM strobes: read in phase two, write in phase four
	assign ram_if.addr  = dmem_addr;
	assign ram_if.wdata = alu_res.res;
	assign ram_if.rd_en = (phase_reg == core_pkg::PH_TWO) && is_ram; // [RQ6]
	assign ram_if.wr_en = (phase_reg == core_pkg::PH_FOUR) && wr_file && is_ram &&
		master_clear_pin_n_i; // [RQ6]

	// Phase sequencing, fetch and execute next values
	always_comb begin
		phase_next = phase_reg;
		pc_next = pc_reg;
		fetch_addr_next = fetch_addr_reg;
		opcode_next = opcode_reg;
		w_next = w_reg;
		status_next = status_reg;
		fsr_next = fsr_reg;
		operand_next = operand_reg;
		fetch_pointer_upper_hold_next = fetch_pointer_upper_hold_reg;
		irq_ack_next = 1'b0;
		case (phase_reg) // [RQ1]
			core_pkg::PH_ONE: begin
				phase_next = core_pkg::PH_TWO;
				fetch_addr_next = pc_reg & PROG_LAST; // [RQ2] [RQ9]
				pc_next = (pc_reg + 13'h0001) & PROG_LAST; // [RQ8] [RQ9]
			end
			core_pkg::PH_TWO: phase_next = core_pkg::PH_THREE;
			core_pkg::PH_THREE: begin
				phase_next = core_pkg::PH_FOUR;
				operand_next = is_ram ? ram_if.rdata : sfr_rd;
			end
			core_pkg::PH_FOUR: begin
				phase_next = core_pkg::PH_ONE;
				opcode_next = prog_data_i; // [RQ2] [RQ3] [RQ7]
				if (wr_w) begin
					w_next = alu_res.res; // [RQ17]
				end
				if (wr_file && !is_ram) begin
					case (dmem_addr[6:0])
						`ADDR_STATUS: status_next = (status_reg & ~`STATUS_WMASK) |
							(alu_res.res & `STATUS_WMASK);
						`ADDR_FSR:    fsr_next = alu_res.res;
						`ADDR_FETCH_POINTER_UPPER_HOLD: fetch_pointer_upper_hold_next = alu_res.res[4:0];
						default:      fetch_pointer_upper_hold_next = fetch_pointer_upper_hold_reg;
					endcase
				end
				// Flags from the arithmetic unit win over a direct status write
				if (alu_res.z_upd) begin
					status_next[`BIT_Z] = (alu_res.res == 8'h00); // [RQ18]
				end
				if (alu_res.c_upd) begin
					status_next[`BIT_C] = alu_res.c; // [RQ18] [RQ19]
				end
				if (alu_res.dc_upd) begin
					status_next[`BIT_DC] = alu_res.dc; // [RQ18] [RQ19]
				end
				if (is_jump) begin
					pc_next = jump_target & PROG_LAST; // [RQ4] [RQ9]
				end else if (pcl_write) begin
					pc_next = {fetch_pointer_upper_hold_reg, alu_res.res} & PROG_LAST; // [RQ4]
				end else if (irq_req_i) begin
					pc_next = `IRQ_VECTOR; // [RQ10]
					irq_ack_next = 1'b1;
				end
				if (flush || irq_req_i) begin
					opcode_next = `NOP_WORD; // [RQ4]
				end
			end
			default: phase_next = core_pkg::PH_ONE;
		endcase
		if (!master_clear_pin_n_i) begin // [RQ21]
			phase_next = core_pkg::PH_ONE;
			pc_next = `RESET_VECTOR; // [RQ10]
			fetch_addr_next = `RESET_VECTOR;
			opcode_next = `NOP_WORD;
			w_next = `W_RST;
			status_next = `STATUS_RST;
			fsr_next = `FSR_RST;
			fetch_pointer_upper_hold_next = `FETCH_POINTER_UPPER_HOLD_RST;
			irq_ack_next = 1'b0;
		end
		cycle_rate_next = rc_mode_i && master_clear_pin_n_i && // [RQ20]
			((phase_next == core_pkg::PH_THREE) || (phase_next == core_pkg::PH_FOUR));
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_reg <= core_pkg::PH_ONE;
			pc_reg <= `RESET_VECTOR;
			fetch_addr_reg <= `RESET_VECTOR;
			opcode_reg <= `NOP_WORD;
			w_reg <= `W_RST;
			status_reg <= `STATUS_RST;
			fsr_reg <= `FSR_RST;
			operand_reg <= 8'h00;
			fetch_pointer_upper_hold_reg <= `FETCH_POINTER_UPPER_HOLD_RST;
			cycle_rate_reg <= 1'b0;
			irq_ack_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			pc_reg <= pc_next;
			fetch_addr_reg <= fetch_addr_next;
			opcode_reg <= opcode_next;
			w_reg <= w_next;
			status_reg <= status_next;
			fsr_reg <= fsr_next;
			operand_reg <= operand_next;
			fetch_pointer_upper_hold_reg <= fetch_pointer_upper_hold_next;
			cycle_rate_reg <= cycle_rate_next;
			irq_ack_reg <= irq_ack_next;
		end
	end

	assign prog_addr_o  = fetch_addr_reg;
	assign phase_o      = phase_reg;
	assign cycle_rate_o = cycle_rate_reg;
	assign irq_ack_o    = irq_ack_reg;
	assign w_o          = w_reg;
	assign status_o     = status_reg;

	// Checks of sequencing, vectors and flags
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	// Every clock with master clear released steps one phase on, four back to one
	a_phase_period: assert property ( // [RQ1]
		master_clear_pin_n_i |=>
		(2'(phase_reg) == 2'($past(phase_reg) + 2'd1)))
		else $error("phase sequence broken");
	a_fetch_advance: assert property ( // [RQ2]
		(phase_reg == core_pkg::PH_ONE) && master_clear_pin_n_i |=>
		(fetch_addr_reg == ($past(pc_reg) & PROG_LAST)) &&
		(pc_reg == (($past(pc_reg) + 13'h0001) & PROG_LAST)))
		else $error("fetch pointer did not advance in phase one");
	a_branch_flush: assert property ( // [RQ4]
		(phase_reg == core_pkg::PH_FOUR) && is_jump && master_clear_pin_n_i |=>
		(opcode_reg == `NOP_WORD) && (pc_reg == ($past(jump_target) & PROG_LAST)) until
		(phase_reg == core_pkg::PH_TWO))
		else $error("branch did not flush or load target");
	a_ram_timing: assert property ( // [RQ6]
		(ram_if.wr_en |-> phase_reg == core_pkg::PH_FOUR) and
		(ram_if.rd_en |-> phase_reg == core_pkg::PH_TWO))
		else $error("data memory accessed in wrong phase");
	a_wrap_range: assert property ( // [RQ9]
		((fetch_addr_reg & ~PROG_LAST) == 13'h0000) && ((pc_reg & ~PROG_LAST) == 13'h0000))
		else $error("program address outside implemented space");
	a_clear_vector: assert property ( // [RQ21]
		!master_clear_pin_n_i |=> (pc_reg == `RESET_VECTOR) && (phase_reg == core_pkg::PH_ONE))
		else $error("master clear did not reset fetch");
	a_irq_vector: assert property ( // [RQ10]
		irq_ack_o |-> (pc_reg == `IRQ_VECTOR) && (opcode_reg == `NOP_WORD) && !$past(irq_ack_o))
		else $error("interrupt did not vector to 0004h");
	a_sub_borrow: assert property ( // [RQ19]
		(phase_reg == core_pkg::PH_FOUR) && (alu_op == core_pkg::AL_SUB) &&
		master_clear_pin_n_i |=> (status_reg[`BIT_C] == ($past(alu_a) >= $past(w_reg))) &&
		(status_reg[`BIT_DC] == ($past(alu_a[3:0]) >= $past(w_reg[3:0]))))
		else $error("subtract borrow flags wrong");
	a_rate_output: assert property ( // [RQ20]
		$past(rc_mode_i) && $past(master_clear_pin_n_i) |->
		(cycle_rate_o == ((phase_reg == core_pkg::PH_THREE) || (phase_reg == core_pkg::PH_FOUR))))
		else $error("cycle rate output out of step");

endmodule

// ---- tb/prog_mem_model.sv ----
`timescale 1ns/10ps

// Program store with a registered read that goes stale while the address moves
module prog_mem_model (
	input  wire logic        mclk_i,
	input  wire logic [12:0] addr_i,
	output logic      [13:0] data_o
);
	logic [13:0] mem [512];
	logic [12:0] addr_reg;

	// Previous output word inverted for a clock after an address change, then the stored word
	always_ff @(posedge mclk_i) begin
		if (addr_i !== addr_reg) begin
			data_o <= ~data_o;
		end else begin
			data_o <= mem[addr_i[8:0]];
		end
		addr_reg <= addr_i;
	end
endmodule

// ---- tb/test_risc_core_fetch_execute_memmap.sv ----
`timescale 1ns/10ps

module test_risc_core_fetch_execute_memmap;
	localparam logic [12:0] LAST = 13'h01ff;
	logic        mclk_i;
	logic        rst_i;
	logic        master_clear_pin_n_i;
	logic        rc_mode_i;
	logic        irq_req_i;
	logic [13:0] prog_data_i;
	logic [12:0] prog_addr_o;
	logic [1:0]  phase_o;
	logic        cycle_rate_o;
	logic        irq_ack_o;
	logic [7:0]  w_o;
	logic [7:0]  status_o;
	logic [15:0] notes [$];
	logic [15:0] head;
	logic [5:0]  ops [6] = '{6'h30, 6'h3e, 6'h3c, 6'h39, 6'h38, 6'h3a};
	logic [8:0]  at;
	logic [7:0]  lfsr;
	logic [7:0]  ew;
	logic [7:0]  lw;
	logic [7:0]  a;
	logic [7:0]  b;
	logic        ec;
	logic        edc;
	logic        ez;
	logic        erp;
	logic        seen;
	logic [7:0]  last_w;
	logic [12:0] last_addr;
	logic [1:0]  last_phase;
	logic        rc_last;
	int          live_cnt;
	int          k;
	int          mismatches;
	int          n_compared;

	core_sequencer #(.PROG_LAST(LAST)) i_core_sequencer (
		.mclk_i               (mclk_i),
		.rst_i                (rst_i),
		.master_clear_pin_n_i (master_clear_pin_n_i),
		.rc_mode_i            (rc_mode_i),
		.irq_req_i            (irq_req_i),
		.prog_data_i          (prog_data_i),
		.prog_addr_o          (prog_addr_o),
		.phase_o              (phase_o),
		.cycle_rate_o         (cycle_rate_o),
		.irq_ack_o            (irq_ack_o),
		.w_o                  (w_o),
		.status_o             (status_o)
	);

	prog_mem_model i_prog_mem_model (
		.mclk_i (mclk_i),
		.addr_i (prog_addr_o),
		.data_o (prog_data_i)
	);

	// 20 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #25 mclk_i = ~mclk_i;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("Counts: %0d compared, %0d mismatches", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	function automatic logic [7:0] next_rand(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic emit(input logic [13:0] word);
		i_prog_mem_model.mem[at] = word;
		at = at + 9'd1;
	endtask

	// Queue the expected status and W only when W will visibly change
	task automatic note();
		if (ew !== lw) begin
			notes.push_back({2'b00, erp, 2'b11, ez, edc, ec, ew});
		end
		lw = ew;
	endtask

	// Literal instruction plus its expected effect on W and flags
	task automatic lit(input logic [5:0] op, input logic [7:0] kv);
		logic [8:0] s;
		logic [4:0] n;
		emit({op, kv});
		s = (op == 6'h3c) ? {1'b0, kv} - {1'b0, ew} : {1'b0, ew} + {1'b0, kv};
		n = (op == 6'h3c) ? {1'b0, kv[3:0]} - {1'b0, ew[3:0]} : {1'b0, ew[3:0]} + {1'b0, kv[3:0]};
		case (op)
			6'h30: ew = kv;
			6'h39: ew = ew & kv;
			6'h38: ew = ew | kv;
			6'h3a: ew = ew ^ kv;
			default: begin
				ew = s[7:0];
				ec = s[8] ^ (op == 6'h3c);
				edc = n[4] ^ (op == 6'h3c);
			end
		endcase
		if (op != 6'h30) begin
			ez = (ew == 8'h00);
		end
		note();
	endtask

	task automatic movf(input logic [6:0] f, input logic [7:0] v);
		emit(14'h0800 | {7'h00, f});
		ew = v;
		ez = (v == 8'h00);
		note();
	endtask

	task automatic wait_notes(input int left);
		k = 0;
		while (notes.size() != left && k < 6000) begin
			@(negedge mclk_i);
			k++;
		end
		check(16'(notes.size()), 16'(left));
	endtask

	// Per-cycle output watch; each W change retires the oldest queued note
	always @(negedge mclk_i) begin
		if (rst_i || !master_clear_pin_n_i) begin
			live_cnt = 0;
		end else if (live_cnt < 3) begin
			live_cnt++;
		end
		if (live_cnt == 3) begin
			check({14'h0, phase_o}, {14'h0, last_phase + 2'd1});
			check({15'h0, prog_addr_o > LAST}, 16'h0000);
			if (rc_mode_i === rc_last) begin
				check({15'h0, cycle_rate_o}, {15'h0, rc_mode_i & phase_o[1]});
			end
			if (prog_addr_o !== last_addr) begin
				check({14'h0, phase_o}, 16'h0001);
			end
			if (w_o !== last_w) begin
				check({14'h0, phase_o}, 16'h0000);
				head = 16'hffff;
				if (notes.size() > 0) begin
					head = notes.pop_front();
				end
				check({status_o, w_o}, head);
			end
		end
		last_w = w_o;
		last_addr = prog_addr_o;
		last_phase = phase_o;
		rc_last = rc_mode_i;
	end

	// Hang guard
	initial begin
		repeat (20000) @(posedge mclk_i);
		check(16'h0000, 16'h0001);
		finish_test();
	end

	initial begin
		rst_i = 1'b1;
		master_clear_pin_n_i = 1'b1;
		rc_mode_i = 1'b1;
		irq_req_i = 1'b0;
		lfsr = 8'h4e;
		ew = 8'h00;
		lw = 8'h00;
		ec = 1'b0;
		edc = 1'b0;
		ez = 1'b0;
		erp = 1'b0;
		for (int i = 0; i < 512; i++) begin
			i_prog_mem_model.mem[i] = 14'h0000;
		end
		// Reset entry jumps to the main program
		at = 9'h000;
		emit(14'h2810);
		at = 9'h010;
		lit(6'h30, 8'h81);
		for (int i = 0; i < 12; i++) begin
			lfsr = next_rand(lfsr);
			lit(ops[i % 6], lfsr);
		end
		lit(6'h30, 8'h0f);
		lit(6'h3e, 8'hf1);
		lit(6'h30, 8'h06);
		lit(6'h3c, 8'h05);
		// Jump over a word that must be discarded
		emit(14'h2800 | {5'h00, at + 9'd2});
		emit(14'h30ee);
		// Same offset in both banks, then the pointer path
		lfsr = next_rand(lfsr);
		a = {lfsr[7:2], 2'b01};
		b = {~lfsr[7:2], 2'b11};
		lit(6'h30, a);
		emit(14'h00a0);
		emit(14'h1683);
		erp = 1'b1;
		lit(6'h30, b);
		emit(14'h00a0);
		lit(6'h30, 8'h20);
		emit(14'h0084);
		movf(7'h20, b);
		emit(14'h1283);
		erp = 1'b0;
		movf(7'h00, a);
		lit(6'h30, 8'ha0);
		emit(14'h0084);
		movf(7'h00, b);
		// File increment, rotate right through carry, then a bit-test skip
		emit(14'h0aa0);
		movf(7'h20, a + 8'h01);
		emit(14'h0c20);
		{ew, ec} = {ec, ew};
		note();
		emit(14'h1ca0);
		emit(14'h30ee);
		// Interrupt entry, then run off the top of the space
		at = 9'h004;
		lit(6'h30, 8'h44);
		emit(14'h29fd);
		at = 9'h1fd;
		lit(6'h30, 8'h3c);
		lit(6'h30, 8'h5a);
		lit(6'h30, 8'hc3);
		ew = 8'h81;
		note();
		repeat (4) @(posedge mclk_i);
		@(negedge mclk_i);
		check({3'h0, prog_addr_o}, 16'h0000);
		check({status_o, w_o}, 16'h1800);
		@(posedge mclk_i);
		rst_i <= 1'b0;
		wait_notes(5);
		@(posedge mclk_i);
		irq_req_i <= 1'b1;
		rc_mode_i <= 1'b0;
		k = 0;
		while (irq_ack_o !== 1'b1 && k < 20) begin
			@(negedge mclk_i);
			k++;
		end
		check({15'h0, irq_ack_o}, 16'h0001);
		@(posedge mclk_i);
		irq_req_i <= 1'b0;
		seen = 1'b0;
		repeat (8) begin
			@(negedge mclk_i);
			seen = seen | (prog_addr_o === 13'h0004);
		end
		check({15'h0, seen}, 16'h0001);
		wait_notes(0);
		// Master clear in mid-run, then a clean restart
		@(posedge mclk_i);
		master_clear_pin_n_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		@(negedge mclk_i);
		check({1'b0, phase_o, prog_addr_o}, 16'h0000);
		check({status_o, w_o}, 16'h1800);
		lw = 8'h00;
		ec = 1'b0;
		edc = 1'b0;
		ez = 1'b0;
		ew = 8'h81;
		note();
		@(posedge mclk_i);
		master_clear_pin_n_i <= 1'b1;
		wait_notes(0);
		finish_test();
	end
endmodule
